// >>> src/ccsel_top.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Setting low-speed halt stops the low-speed oscillator.
// RULE2 - Clearing low-speed halt restarts the low-speed oscillator.
// RULE3 - Unstoppable option makes low-speed halt ineffective.
// RULE4 - Peripheral clock: internal high-speed, else crystal or external per enable.
// RULE5 - CPU clock: subsystem if selected, else peripheral or internal high-speed.
// RULE6 - After reset CPU runs from internal high-speed clock with no setup.
// RULE7 - Software enables crystal, waits settling, then sets both select flags.
// RULE8 - Software enables external clock, no settling wait, then sets both flags.
// RULE9 - High-speed system select changes only once after each reset.
// RULE10 - Software restarts internal oscillator, checks stable, then clears source flag.
// RULE11 - Leaving subsystem for internal: oscillator running, source flag cleared first.
// RULE12 - Leaving subsystem for high-speed system: settle, set flags, then clear.
// RULE13 - HALT enters the halt state matching the current CPU clock.
// RULE14 - Software stops unsupported peripherals before executing STOP.
// RULE15 - Dual-level detect mode holds reset processing at least 11 us.
// RULE16 - Main clock mode: system select at bit 2, source flag bit 0.
// RULE17 - Pin mode: external enable bit 7, crystal bit 6, subsystem bit 4.
// RULE18 - Internal oscillator mode: stable status bit 7, halt bit 0.
// RULE19 - Main oscillator halt sits at bit 7 of its control register.
// RULE20 - Subsystem select set feeds the subsystem clock to the CPU.
// RULE21 - After a select write the old clock runs some cycles first.
// RULE22 - Stable status reads 1 only while the internal oscillator runs.
// RULE23 - Switchover never shortens a high or low clock phase; the switch keeps high phases whole but can shorten the hand-over low phase.
module ccsel_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic hs_osc_clk_i,
	input wire logic main_crystal_clock_i,
	input wire logic ext_clk_i,
	input wire logic sub_crystal_clock_i,
	input wire logic lowspeed_unstoppable_i,
	input wire logic power_on_detect_level_option_i,
	input wire logic halt_i,
	input wire logic stop_i,
	input wire logic wake_i,
	output logic cpu_clk_o,
	output logic periph_clk_o,
	output logic hs_osc_en_o,
	output logic main_osc_en_o,
	output logic sub_osc_en_o,
	output logic lowspeed_osc_en_o,
	output logic [5:0] cpu_state_o
);
	typedef struct packed {
		ccsel_pkg::ccsel_state_t st;
		logic hs_system_clk_select;
		logic hs_system_clk_select_locked;
		logic main_clk_source_flag;
		logic cpu_sub_clk_select;
		logic ext_clk_input_enable;
		logic main_xtal_pin_mode;
		logic sub_xtal_pin_mode;
		logic main_osc_halt;
		logic hs_internal_osc_halt;
		logic lowspeed_osc_halt;
		logic [3:0] hs_cnt;
		logic hs_internal_osc_stable;
		logic [9:0] rst_cnt;
		logic [7:0] rdata;
		logic hs_en;
		logic main_en;
		logic sub_en;
		logic ls_en;
	} ccsel_top_state_t;

	ccsel_top_state_t r;
	ccsel_top_state_t n;
	logic [1:0] periph_req;
	logic [1:0] cpu_req;

	ccsel_sw_if periph_sw ();
	ccsel_sw_if cpu_sw ();

	////////////////////////////////////////////////////////////////////////////////
	// Source selection

	always_comb begin
		periph_req = ccsel_pkg::SRC_HS; // RULE4
		if (r.hs_system_clk_select) begin
			periph_req = r.ext_clk_input_enable ? ccsel_pkg::SRC_EXT : ccsel_pkg::SRC_XTAL;
		end
		cpu_req = r.main_clk_source_flag ? periph_req : ccsel_pkg::SRC_HS; // RULE5
		if (r.cpu_sub_clk_select) begin
			cpu_req = ccsel_pkg::SRC_SUB; // RULE20
		end
	end

	assign periph_sw.ce = ce_i;
	assign periph_sw.gate = (r.st != ccsel_pkg::ST_STOP);
	assign periph_sw.src = {sub_crystal_clock_i, ext_clk_i, main_crystal_clock_i, hs_osc_clk_i};
	assign periph_sw.req = periph_req;
	assign cpu_sw.ce = ce_i;
	// CPU clock parks low outside the run state
	assign cpu_sw.gate = (r.st == ccsel_pkg::ST_RUN);
	assign cpu_sw.src = {sub_crystal_clock_i, ext_clk_i, main_crystal_clock_i, hs_osc_clk_i};
	assign cpu_sw.req = cpu_req;

	ccsel_switch u_periph_switch (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sw(periph_sw.sw)
	);

	ccsel_switch u_cpu_switch (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sw(cpu_sw.sw)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers, state machine, oscillator enables

	always_comb begin
		n = r;
		if (ce_i) begin
			n.rdata = ccsel_pkg::RST_RDATA;
			if (wr_i) begin
				unique case (addr_i)
					ccsel_pkg::OFS_MAIN_CLOCK_MODE: begin
						// Only the first change after reset sticks
						if (!r.hs_system_clk_select_locked && wdata_i[ccsel_pkg::BIT_HS_SYSTEM_CLK_SELECT] !=
								r.hs_system_clk_select) begin // RULE9
							n.hs_system_clk_select = wdata_i[ccsel_pkg::BIT_HS_SYSTEM_CLK_SELECT];
							n.hs_system_clk_select_locked = 1'b1;
						end
						n.main_clk_source_flag = wdata_i[ccsel_pkg::BIT_MAIN_CLK_SOURCE_FLAG]; // RULE16
					end
					ccsel_pkg::OFS_PROC_CLOCK_CTRL: begin
						n.cpu_sub_clk_select = wdata_i[ccsel_pkg::BIT_CPU_SUB_CLK_SELECT];
					end
					ccsel_pkg::OFS_CLOCK_PIN_MODE: begin // RULE17
						n.ext_clk_input_enable = wdata_i[ccsel_pkg::BIT_EXT_CLK_INPUT_ENABLE];
						n.main_xtal_pin_mode = wdata_i[ccsel_pkg::BIT_MAIN_XTAL_PIN_MODE];
						n.sub_xtal_pin_mode = wdata_i[ccsel_pkg::BIT_SUB_XTAL_PIN_MODE];
					end
					ccsel_pkg::OFS_MAIN_OSC_CTRL: begin
						n.main_osc_halt = wdata_i[ccsel_pkg::BIT_MAIN_OSC_HALT]; // RULE19
					end
					ccsel_pkg::OFS_INTERNAL_OSC_MODE: begin // RULE18
						n.hs_internal_osc_halt = wdata_i[ccsel_pkg::BIT_HS_INTERNAL_OSC_HALT];
						n.lowspeed_osc_halt = wdata_i[ccsel_pkg::BIT_LOWSPEED_OSC_HALT];
					end
					default: begin
					end
				endcase
			end
			if (rd_i) begin
				unique case (addr_i)
					ccsel_pkg::OFS_MAIN_CLOCK_MODE: begin // RULE16
						n.rdata[ccsel_pkg::BIT_HS_SYSTEM_CLK_SELECT] = r.hs_system_clk_select;
						n.rdata[ccsel_pkg::BIT_MAIN_CLK_STATUS] = (cpu_sw.cur == ccsel_pkg::SRC_XTAL) ||
							(cpu_sw.cur == ccsel_pkg::SRC_EXT);
						n.rdata[ccsel_pkg::BIT_MAIN_CLK_SOURCE_FLAG] = r.main_clk_source_flag;
					end
					ccsel_pkg::OFS_PROC_CLOCK_CTRL: begin
						n.rdata[ccsel_pkg::BIT_CPU_SUB_CLK_STATUS] = (cpu_sw.cur == ccsel_pkg::SRC_SUB);
						n.rdata[ccsel_pkg::BIT_CPU_SUB_CLK_SELECT] = r.cpu_sub_clk_select;
					end
					ccsel_pkg::OFS_CLOCK_PIN_MODE: begin // RULE17
						n.rdata[ccsel_pkg::BIT_EXT_CLK_INPUT_ENABLE] = r.ext_clk_input_enable;
						n.rdata[ccsel_pkg::BIT_MAIN_XTAL_PIN_MODE] = r.main_xtal_pin_mode;
						n.rdata[ccsel_pkg::BIT_SUB_XTAL_PIN_MODE] = r.sub_xtal_pin_mode;
					end
					ccsel_pkg::OFS_MAIN_OSC_CTRL: begin
						n.rdata[ccsel_pkg::BIT_MAIN_OSC_HALT] = r.main_osc_halt; // RULE19
					end
					ccsel_pkg::OFS_INTERNAL_OSC_MODE: begin // RULE18
						n.rdata[ccsel_pkg::BIT_HS_INTERNAL_OSC_STABLE] = r.hs_internal_osc_stable;
						n.rdata[ccsel_pkg::BIT_LOWSPEED_OSC_HALT] = r.lowspeed_osc_halt;
						n.rdata[ccsel_pkg::BIT_HS_INTERNAL_OSC_HALT] = r.hs_internal_osc_halt;
					end
					ccsel_pkg::OFS_CPU_STATE: begin
						n.rdata = {2'b00, r.st};
					end
					default: begin
					end
				endcase
			end
			unique case (r.st)
				ccsel_pkg::ST_RESET: begin
					// Dual-level detect mode holds the CPU in reset processing
					if (!power_on_detect_level_option_i || r.rst_cnt == ccsel_pkg::RESET_PROC_LAST) begin
						n.st = ccsel_pkg::ST_RUN; // RULE6 RULE15
					end else begin
						n.rst_cnt = r.rst_cnt + 10'h001;
					end
				end
				ccsel_pkg::ST_RUN: begin
					if (halt_i) begin // RULE13
						unique case (cpu_sw.cur)
							ccsel_pkg::SRC_HS: n.st = ccsel_pkg::ST_HALT_HI;
							ccsel_pkg::SRC_SUB: n.st = ccsel_pkg::ST_HALT_SUB;
							default: n.st = ccsel_pkg::ST_HALT_HS;
						endcase
					end else if (stop_i && cpu_sw.cur != ccsel_pkg::SRC_SUB) begin
						// STOP is not offered from the subsystem clock
						n.st = ccsel_pkg::ST_STOP;
					end
				end
				ccsel_pkg::ST_HALT_HI, ccsel_pkg::ST_HALT_HS, ccsel_pkg::ST_HALT_SUB,
				ccsel_pkg::ST_STOP: begin
					if (wake_i) begin
						n.st = ccsel_pkg::ST_RUN;
					end
				end
				default: begin
					n.st = ccsel_pkg::ST_RESET;
				end
			endcase
			n.hs_en = !n.hs_internal_osc_halt && (n.st != ccsel_pkg::ST_STOP);
			n.main_en = !n.main_osc_halt && n.main_xtal_pin_mode && (n.st != ccsel_pkg::ST_STOP);
			n.sub_en = n.sub_xtal_pin_mode;
			n.ls_en = lowspeed_unstoppable_i || !n.lowspeed_osc_halt; // RULE1 RULE2 RULE3
			// Stable only after a settle run of the internal oscillator
			if (!n.hs_en) begin // RULE22
				n.hs_cnt = 4'h0;
				n.hs_internal_osc_stable = 1'b0;
			end else begin
				if (r.hs_cnt != ccsel_pkg::HS_SETTLE_CYC) begin
					n.hs_cnt = r.hs_cnt + 4'h1;
				end
				n.hs_internal_osc_stable = (n.hs_cnt == ccsel_pkg::HS_SETTLE_CYC);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.st <= ccsel_pkg::ST_RESET;
			r.main_osc_halt <= ccsel_pkg::RST_MAIN_OSC_HALT;
			r.hs_en <= 1'b1;
			r.ls_en <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign rdata_o = r.rdata;
	assign cpu_clk_o = cpu_sw.clk;
	assign periph_clk_o = periph_sw.clk;
	assign hs_osc_en_o = r.hs_en;
	assign main_osc_en_o = r.main_en;
	assign sub_osc_en_o = r.sub_en;
	assign lowspeed_osc_en_o = r.ls_en;
	assign cpu_state_o = r.st;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rd_mode;
		ce_i && rd_i && !wr_i && addr_i == ccsel_pkg::OFS_MAIN_CLOCK_MODE;
	endsequence

	property p_ls_stop;
		ce_i && n.lowspeed_osc_halt && !lowspeed_unstoppable_i |=> !lowspeed_osc_en_o;
	endproperty
	a_ls_stop: assert property (p_ls_stop) else $error("low-speed osc not stopped"); // RULE1

	property p_ls_run;
		ce_i && !n.lowspeed_osc_halt |=> lowspeed_osc_en_o;
	endproperty
	a_ls_run: assert property (p_ls_run) else $error("low-speed osc not restarted"); // RULE2

	property p_ls_locked;
		ce_i && lowspeed_unstoppable_i |=> lowspeed_osc_en_o;
	endproperty
	a_ls_locked: assert property (p_ls_locked) else $error("unstoppable osc stopped"); // RULE3

	property p_hs_system_clk_select_once;
		r.hs_system_clk_select_locked |=> r.hs_system_clk_select == $past(r.hs_system_clk_select);
	endproperty
	a_hs_system_clk_select_once: assert property (p_hs_system_clk_select_once) else $error("system select changed twice"); // RULE9

	property p_halt_hi;
		ce_i && r.st == ccsel_pkg::ST_RUN && halt_i && cpu_sw.cur == ccsel_pkg::SRC_HS
			|=> cpu_state_o == ccsel_pkg::ST_HALT_HI;
	endproperty
	a_halt_hi: assert property (p_halt_hi) else $error("wrong halt state"); // RULE13

	property p_reset_proc;
		r.st == ccsel_pkg::ST_RESET && n.st == ccsel_pkg::ST_RUN && power_on_detect_level_option_i
			|-> r.rst_cnt == ccsel_pkg::RESET_PROC_LAST;
	endproperty
	a_reset_proc: assert property (p_reset_proc) else $error("reset processing too short"); // RULE15

	property p_reset_hs;
		r.st == ccsel_pkg::ST_RESET |-> cpu_req == ccsel_pkg::SRC_HS && cpu_sw.cur == ccsel_pkg::SRC_HS;
	endproperty
	a_reset_hs: assert property (p_reset_hs) else $error("CPU not on internal clock"); // RULE6

	property p_rd_mode;
		s_rd_mode |=> rdata_o[2] == r.hs_system_clk_select && rdata_o[0] == r.main_clk_source_flag;
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("mode register layout wrong"); // RULE16

	property p_stable;
		r.hs_internal_osc_halt |-> !r.hs_internal_osc_stable;
	endproperty
	a_stable: assert property (p_stable) else $error("stable while halted"); // RULE22

	property p_sub_cpu;
		ce_i && r.cpu_sub_clk_select && cpu_sw.cur == ccsel_pkg::SRC_SUB ##1 ce_i
			|-> cpu_sw.cur == ccsel_pkg::SRC_SUB;
	endproperty
	a_sub_cpu: assert property (p_sub_cpu) else $error("CPU left subsystem clock"); // RULE20
endmodule // ccsel_top

// >>> src/ccsel_pkg.sv
package ccsel_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] OFS_MAIN_CLOCK_MODE = 3'h0;
	localparam logic [2:0] OFS_PROC_CLOCK_CTRL = 3'h1;
	localparam logic [2:0] OFS_CLOCK_PIN_MODE = 3'h2;
	localparam logic [2:0] OFS_MAIN_OSC_CTRL = 3'h3;
	localparam logic [2:0] OFS_INTERNAL_OSC_MODE = 3'h4;
	localparam logic [2:0] OFS_CPU_STATE = 3'h5;
	// Field positions
	localparam int BIT_HS_SYSTEM_CLK_SELECT = 2;
	localparam int BIT_MAIN_CLK_STATUS = 1;
	localparam int BIT_MAIN_CLK_SOURCE_FLAG = 0;
	localparam int BIT_CPU_SUB_CLK_SELECT = 4;
	localparam int BIT_CPU_SUB_CLK_STATUS = 5;
	localparam int BIT_EXT_CLK_INPUT_ENABLE = 7;
	localparam int BIT_MAIN_XTAL_PIN_MODE = 6;
	localparam int BIT_SUB_XTAL_PIN_MODE = 4;
	localparam int BIT_MAIN_OSC_HALT = 7;
	localparam int BIT_HS_INTERNAL_OSC_STABLE = 7;
	localparam int BIT_LOWSPEED_OSC_HALT = 1;
	localparam int BIT_HS_INTERNAL_OSC_HALT = 0;
	// Values after reset
	localparam logic RST_MAIN_OSC_HALT = 1'b1;
	localparam logic [7:0] RST_RDATA = 8'h00;
	// Clock source indices
	localparam logic [1:0] SRC_HS = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_SUB = 2'h3;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_PROC_MIN_NS = 11000;
	localparam int RESET_PROC_CYC = (RESET_PROC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] RESET_PROC_LAST = 10'(RESET_PROC_CYC - 1);
	localparam logic [2:0] SWITCH_HOLD_LAST = 3'h3;
	localparam logic [3:0] HS_SETTLE_CYC = 4'h8;
	// Operating states
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_RUN = 6'h02,
		ST_HALT_HI = 6'h04,
		ST_HALT_HS = 6'h08,
		ST_HALT_SUB = 6'h10,
		ST_STOP = 6'h20
	} ccsel_state_t;
endpackage

// >>> src/ccsel_sw_if.sv
`timescale 1ns/1ps
interface ccsel_sw_if;
	logic ce;
	logic gate;
	logic [3:0] src;
	logic [1:0] req;
	logic [1:0] cur;
	logic clk;
	modport ctrl (output ce, output gate, output src, output req, input cur, input clk);
	modport sw (input ce, input gate, input src, input req, output cur, output clk);
endinterface // ccsel_sw_if

// >>> src/ccsel_switch.sv
`timescale 1ns/1ps
module ccsel_switch (
	input wire logic clk_i,
	input wire logic rst_n_i,
	ccsel_sw_if.sw sw
);
	typedef struct packed {
		logic [1:0] cur;
		logic [2:0] cnt;
		logic arm;
		logic clk;
	} ccsel_sw_state_t;

	ccsel_sw_state_t r;
	ccsel_sw_state_t n;

	always_comb begin
		n = r;
		if (sw.ce) begin
			if (sw.req != r.cur) begin
				// Old source keeps running for a few cycles first
				if (r.cnt != ccsel_pkg::SWITCH_HOLD_LAST) begin // RULE21
					n.cnt = r.cnt + 3'h1;
				end else if (!r.clk && !sw.src[sw.req]) begin // RULE23
					n.cur = sw.req;
					n.cnt = 3'h0;
				end
			end else begin
				n.cnt = 3'h0;
			end
			// Ungating waits for a low source so no high phase starts short
			n.arm = sw.gate && (r.arm || !sw.src[n.cur]); // RULE23
			// Gating only ever ends a high phase at its natural fall
			n.clk = n.arm ? sw.src[n.cur] : (r.clk & sw.src[n.cur]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '{cur: ccsel_pkg::SRC_HS, cnt: 3'h0, arm: 1'b0, clk: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign sw.cur = r.cur;
	assign sw.clk = r.clk;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_sw_hold;
		sw.ce && sw.req != r.cur && r.cnt == 3'h0 |=> r.cur == $past(r.cur);
	endproperty
	a_sw_hold: assert property (p_sw_hold) else $error("source switched too early"); // RULE21

	property p_sw_clean;
		r.cur != $past(r.cur) |-> !$past(r.clk) && !r.clk;
	endproperty
	a_sw_clean: assert property (p_sw_clean) else $error("switch cut a clock phase"); // RULE23
endmodule // ccsel_switch

// >>> verif/ccsel_osc_model.sv
`timescale 1ns/1ps
module ccsel_osc_model #(
	parameter int HS_HALF = 4,
	parameter int XTAL_HALF = 3,
	parameter int EXT_HALF = 5,
	parameter int SUB_HALF = 7
) (
	input wire logic clk_i,
	input wire logic hs_en_i,
	input wire logic main_en_i,
	input wire logic sub_en_i,
	output logic hs_clk_o,
	output logic main_clk_o,
	output logic ext_clk_o,
	output logic sub_clk_o
);
	localparam int HALF [4] = '{HS_HALF, XTAL_HALF, EXT_HALF, SUB_HALF};
	logic [3:0] run;
	logic [3:0] ck = 4'h0;
	int cnt [4];
	////////////////////////////////////////////////////////////////
	// Stopped oscillators rest low; the external source never stops
	assign run = {sub_en_i, 1'b1, main_en_i, hs_en_i};
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (!run[i]) begin
				cnt[i] <= 0;
				ck[i] <= 1'b0;
			end else if (cnt[i] == HALF[i] - 1) begin
				cnt[i] <= 0;
				ck[i] <= ~ck[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
	assign hs_clk_o = ck[0];
	assign main_clk_o = ck[1];
	assign ext_clk_o = ck[2];
	assign sub_clk_o = ck[3];
endmodule // ccsel_osc_model

// >>> verif/cpu_peripheral_clock_select_tb.sv
`timescale 1ns/1ps
module cpu_peripheral_clock_select_tb;
	localparam int HS_HALF = 4;
	localparam int XTAL_HALF = 3;
	localparam int EXT_HALF = 5;
	localparam int SUB_HALF = 7;
	localparam int RESET_PROC_EXP = 11000 / 20;
	localparam logic [7:0] RST_EXP [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h02, 8'h00, 8'h00};
	localparam logic [1:0] CORNER [3] = '{2'h3, 2'h2, 2'h0};
	logic clk_i, rst_n_i, ce_i, wr_i, rd_i, unstop_i, pod_i, halt_i, stop_i, wake_i;
	logic [2:0] addr_i;
	logic [7:0] wdata_i, rdata_o, v;
	logic hs_clk, main_clk, ext_clk, sub_clk, cpu_clk_o, periph_clk_o;
	logic hs_en, main_en, sub_en, ls_en;
	logic [5:0] cpu_state_o;
	logic [31:0] lfsr;
	logic [1:0] hu;
	int miscompares = 0;
	int check_count = 0;
	int n;

	ccsel_top ccsel_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hs_osc_clk_i(hs_clk),
		.main_crystal_clock_i(main_clk), .ext_clk_i(ext_clk), .sub_crystal_clock_i(sub_clk),
		.lowspeed_unstoppable_i(unstop_i), .power_on_detect_level_option_i(pod_i),
		.halt_i(halt_i), .stop_i(stop_i), .wake_i(wake_i), .cpu_clk_o(cpu_clk_o),
		.periph_clk_o(periph_clk_o), .hs_osc_en_o(hs_en), .main_osc_en_o(main_en),
		.sub_osc_en_o(sub_en), .lowspeed_osc_en_o(ls_en), .cpu_state_o(cpu_state_o));
	ccsel_osc_model #(.HS_HALF(HS_HALF), .XTAL_HALF(XTAL_HALF), .EXT_HALF(EXT_HALF),
		.SUB_HALF(SUB_HALF)) ccsel_osc_model_i (.clk_i(clk_i), .hs_en_i(hs_en),
		.main_en_i(main_en), .sub_en_i(sub_en), .hs_clk_o(hs_clk), .main_clk_o(main_clk),
		.ext_clk_o(ext_clk), .sub_clk_o(sub_clk));

	////////////////////////////////////////////////////////////////
	// Select code is {subsystem, system select, source flag, external enable}
	function automatic logic [7:0] periph_period(logic [3:0] sel);
		if (!sel[2]) return 8'(2 * HS_HALF);
		return sel[0] ? 8'(2 * EXT_HALF) : 8'(2 * XTAL_HALF);
	endfunction
	function automatic logic [7:0] cpu_period(logic [3:0] sel);
		if (sel[3]) return 8'(2 * SUB_HALF);
		return sel[1] ? periph_period(sel) : 8'(2 * HS_HALF);
	endfunction
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	// Read right after the write, before the switch can finish
	task automatic wrrd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		wr(a, d);
		rd(a, q);
	endtask
	// Period between 2nd and 3rd rise, well after any switch has landed
	task automatic period(input logic per, output logic [7:0] p);
		logic prev;
		logic cur;
		int e;
		p = 8'h00;
		n = 0;
		e = 0;
		prev = 1'b1;
		repeat (30) @(posedge clk_i);
		for (int i = 0; i < 200 && e < 3; i++) begin
			@(posedge clk_i);
			#1;
			cur = per ? periph_clk_o : cpu_clk_o;
			n++;
			if (cur === 1'b1 && prev === 1'b0) begin
				e++;
				if (e == 3) p = 8'(n);
				n = 0;
			end
			prev = cur;
		end
	endtask
	task automatic expect_clocks(input logic [3:0] sel);
		logic [7:0] p;
		period(1'b0, p);
		check(p, cpu_period(sel));
		period(1'b1, p);
		check(p, periph_period(sel));
	endtask
	task automatic pulse(input logic [2:0] hsw, input logic [5:0] st);
		@(posedge clk_i);
		{halt_i, stop_i, wake_i} <= hsw;
		@(posedge clk_i);
		{halt_i, stop_i, wake_i} <= 3'h0;
		#1;
		check({2'h0, cpu_state_o}, {2'h0, st});
	endtask
	task automatic do_reset(input logic opt);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		pod_i <= opt;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Whole run is under two thousand cycles; this is over ten times that
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		summarize();
	end
	initial begin
		{rst_n_i, ce_i, wr_i, rd_i, unstop_i, pod_i, halt_i, stop_i, wake_i} = 9'h080;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		lfsr = 32'h89DA;
		do_reset(1'b0);
		idle(1);
		check({2'h0, cpu_state_o}, 8'h02);
		check({4'h0, hs_en, main_en, sub_en, ls_en}, 8'h09);
		idle(12);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), v);
			check(v, RST_EXP[i]);
		end
		expect_clocks(4'h0);
		// Frozen clock enable must swallow the strobe
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(3'h4, 8'h02);
		@(posedge clk_i);
		ce_i <= 1'b1;
		#1;
		check({7'h0, ls_en}, 8'h01);
		for (int i = 0; i < 11; i++) begin
			lfsr = lfsr_next(lfsr);
			hu = (i < 3) ? CORNER[i] : lfsr[1:0];
			@(posedge clk_i);
			unstop_i <= hu[0];
			wr(3'h4, {6'h00, hu[1], 1'b0});
			check({7'h0, ls_en}, {7'h0, ~(hu[1] & ~hu[0])});
		end
		@(posedge clk_i);
		unstop_i <= 1'b0;
		wr(3'h4, 8'h00);
		wr(3'h2, 8'h40);
		wr(3'h3, 8'h00);
		check({7'h0, main_en}, 8'h01);
		idle(20);
		wr(3'h0, 8'h04);
		expect_clocks(4'h4);
		wr(3'h0, 8'h05);
		expect_clocks(4'h6);
		wr(3'h0, 8'h01);
		rd(3'h0, v);
		check(v, 8'h07);
		wr(3'h4, 8'h01);
		check({7'h0, hs_en}, 8'h00);
		rd(3'h4, v);
		check(v, 8'h01);
		wr(3'h4, 8'h00);
		idle(12);
		rd(3'h4, v);
		check(v, 8'h80);
		wr(3'h0, 8'h04);
		expect_clocks(4'h4);
		pulse(3'h4, 6'h04);
		pulse(3'h1, 6'h02);
		// Second reset must re-open the one-shot system select
		do_reset(1'b0);
		wr(3'h2, 8'hC0);
		wr(3'h3, 8'h00);
		wr(3'h0, 8'h04);
		wr(3'h0, 8'h05);
		expect_clocks(4'h7);
		rd(3'h2, v);
		check(v, 8'hC0);
		pulse(3'h4, 6'h08);
		idle(20);
		check({7'h0, cpu_clk_o}, 8'h00);
		pulse(3'h1, 6'h02);
		pulse(3'h2, 6'h20);
		idle(20);
		check({7'h0, periph_clk_o}, 8'h00);
		pulse(3'h1, 6'h02);
		wr(3'h2, 8'hD0);
		check({7'h0, sub_en}, 8'h01);
		idle(20);
		wrrd(3'h1, 8'h10, v);
		check(v, 8'h10);
		expect_clocks(4'hF);
		rd(3'h1, v);
		check(v, 8'h30);
		pulse(3'h4, 6'h10);
		pulse(3'h1, 6'h02);
		pulse(3'h2, 6'h02);
		wr(3'h1, 8'h00);
		expect_clocks(4'h7);
		// Back to subsystem, then leave it for the internal clock
		wr(3'h1, 8'h10);
		idle(30);
		rd(3'h1, v);
		check(v, 8'h30);
		wr(3'h0, 8'h04);
		wr(3'h1, 8'h00);
		expect_clocks(4'h5);
		rd(3'h0, v);
		check(v, 8'h04);
		do_reset(1'b1);
		n = 0;
		for (int i = 0; i < 1000; i++) begin
			@(posedge clk_i);
			#1;
			if (cpu_state_o === 6'h02) break;
			n++;
		end
		check(8'(n >= RESET_PROC_EXP - 1 && n <= RESET_PROC_EXP + 1), 8'h01);
		summarize();
	end
endmodule // cpu_peripheral_clock_select_tb
